// >>> cfm_defines.svh
// constants for the contactor feedback monitor
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH
`define CFM_CLK_MHZ 100
`define CFM_WINDOW_MS 500
`define CFM_WINDOW_CYC (`CFM_WINDOW_MS * 1000 * `CFM_CLK_MHZ)
`define CFM_CNT_W 26
`define CFM_LOAD_LAG 1
`endif

// >>> cfm_pkg.sv
// types for the contactor feedback monitor
`default_nettype none
package cfm_pkg;
	typedef enum logic [2:0] {
		CFM_OFF,
		CFM_ON_OPEN_WAIT,
		CFM_ON,
		CFM_CLOSE_WAIT,
		CFM_FAULT
	} cfm_state_t;
endpackage : cfm_pkg
`default_nettype wire

// >>> cfm_timer.sv
// loadable down counter that flags expiry of a supervision window
`default_nettype none
`include "cfm_defines.svh"
module cfm_timer #(
	parameter int WIDTH = `CFM_CNT_W
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic start,
	input wire logic stop,
	input wire logic [WIDTH-1:0] load_val,
	output logic expired
);
	logic [WIDTH-1:0] cnt_q;
	logic run_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				cnt_q <= load_val;
				run_q <= 1'b1;
			end else if (stop) begin
				run_q <= 1'b0;
			end else if (run_q && cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
	// expiry reads registered state only, so the controller can act on it without a loop
	assign expired = run_q && (cnt_q == '0);
endmodule : cfm_timer
`default_nettype wire

// >>> cfm_monitor.sv
// contactor feedback monitor: supervises safety switching outputs via feedback loop
// Notes on behaviour
// - supervision acts only when monitoring is enabled; else feedback is ignored
// - switch-on is withheld unless the feedback loop reads closed
// - after release the loop must open within 500 ms, else fault
// - after switch-off the loop must reclose within 500 ms, else fault
// - any timing fault forces outputs off and enters fault interlock
// - entering interlock from a feedback fault pulses a display message request
`default_nettype none
`include "cfm_defines.svh"
module cfm_monitor #(
	parameter int WINDOW_CYC = `CFM_WINDOW_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic monitor_enable,
	input wire logic release_req,
	input wire logic contactor_feedback_input,
	input wire logic fault_clear,
	output logic safety_switching_outputs,
	output logic fault_interlock,
	output logic display_fault_req
);
	// =====================================================
	// state and timer
	cfm_pkg::cfm_state_t state_q;
	cfm_pkg::cfm_state_t state_d;
	logic fb_closed;
	logic t_start;
	logic t_stop;
	logic t_expired;
	logic to_fault;
	logic [`CFM_CNT_W-1:0] win_load;

	// high level on the input means the normally closed loop is closed
	assign fb_closed = contactor_feedback_input;
	// one cycle goes to loading, so load one less for an exact window
	// a window of zero cycles wraps the load to the full counter range instead of expiring
	assign win_load = `CFM_CNT_W'(WINDOW_CYC - `CFM_LOAD_LAG);

	// the timer runs only in the two wait states; every exit stops or reloads it
	cfm_timer #(
		.WIDTH(`CFM_CNT_W)
	) u_timer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.start(t_start),
		.stop(t_stop),
		.load_val(win_load),
		.expired(t_expired)
	);

	// =====================================================
	// next state
	always_comb begin
		state_d = state_q;
		t_start = 1'b0;
		t_stop = 1'b0;
		case (state_q)
			cfm_pkg::CFM_OFF: begin
				if (release_req && (!monitor_enable || fb_closed)) begin
					state_d = monitor_enable ? cfm_pkg::CFM_ON_OPEN_WAIT : cfm_pkg::CFM_ON;
					t_start = monitor_enable;
				end
			end
			cfm_pkg::CFM_ON_OPEN_WAIT: begin
				if (!release_req) begin
					state_d = monitor_enable ? cfm_pkg::CFM_CLOSE_WAIT : cfm_pkg::CFM_OFF;
					t_start = monitor_enable;
					t_stop = !monitor_enable;
				end else if (!fb_closed || !monitor_enable) begin
					state_d = cfm_pkg::CFM_ON;
					t_stop = 1'b1;
				end else if (t_expired) begin
					state_d = cfm_pkg::CFM_FAULT;
					t_stop = 1'b1;
				end
			end
			cfm_pkg::CFM_ON: begin
				if (!release_req) begin
					state_d = monitor_enable ? cfm_pkg::CFM_CLOSE_WAIT : cfm_pkg::CFM_OFF;
					t_start = monitor_enable;
				end
			end
			cfm_pkg::CFM_CLOSE_WAIT: begin
				// dropping the option mid-window abandons supervision instead of faulting
				if (fb_closed || !monitor_enable) begin
					state_d = cfm_pkg::CFM_OFF;
					t_stop = 1'b1;
				end else if (t_expired) begin
					state_d = cfm_pkg::CFM_FAULT;
					t_stop = 1'b1;
				end
			end
			cfm_pkg::CFM_FAULT: begin
				if (fault_clear) begin
					state_d = cfm_pkg::CFM_OFF;
				end
			end
			default: begin
				state_d = cfm_pkg::CFM_FAULT;
			end
		endcase
	end

	assign to_fault = (state_d == cfm_pkg::CFM_FAULT) && (state_q != cfm_pkg::CFM_FAULT);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= cfm_pkg::CFM_OFF;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// =====================================================
	// registered outputs
	// decoded from the next state so the pins move on the same edge as the state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			safety_switching_outputs <= 1'b0;
			fault_interlock <= 1'b0;
		end else if (clk_en) begin
			safety_switching_outputs <= (state_d == cfm_pkg::CFM_ON_OPEN_WAIT)
				|| (state_d == cfm_pkg::CFM_ON);
			fault_interlock <= (state_d == cfm_pkg::CFM_FAULT);
		end
	end

	// a pulse rather than a level: display logic latches its own message
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			display_fault_req <= 1'b0;
		end else if (clk_en) begin
			display_fault_req <= to_fault;
		end else begin
			display_fault_req <= 1'b0;
		end
	end

	// =====================================================
	// checks
	// internal nets are watched directly so a fault is caught at its deciding edge
	sequence fault_entry_s;
		!fault_interlock ##1 fault_interlock;
	endsequence

	sequence switch_on_s;
		!safety_switching_outputs ##1 safety_switching_outputs;
	endsequence

	outputs_off_fault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		fault_interlock |-> !safety_switching_outputs)
		else $error("outputs on during interlock");

	fault_msg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		fault_entry_s |-> display_fault_req)
		else $error("no display request at fault entry");

	msg_only_entry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		display_fault_req |-> fault_interlock && !$past(fault_interlock))
		else $error("display request without fault entry");

	switch_on_closed_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		clk_en && $rose(safety_switching_outputs) && $past(monitor_enable)
		|-> $past(fb_closed))
		else $error("switch-on with open loop");

	latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		fault_interlock && !fault_clear |=> fault_interlock)
		else $error("interlock dropped without clear");

	no_fault_disabled_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!monitor_enable && state_q == cfm_pkg::CFM_ON && clk_en && release_req
		|=> safety_switching_outputs)
		else $error("feedback influenced outputs while disabled");

	open_timeout_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_ON_OPEN_WAIT && clk_en && t_expired && release_req
		&& fb_closed |=> fault_interlock && !safety_switching_outputs)
		else $error("open timeout not faulted");

	close_timeout_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_CLOSE_WAIT && clk_en && t_expired && !fb_closed
		|=> fault_interlock)
		else $error("close timeout not faulted");

	refuse_open_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_OFF && clk_en && monitor_enable && !fb_closed
		|=> !safety_switching_outputs)
		else $error("switch-on not withheld with open loop");

	on_from_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		switch_on_s |-> $past(state_q) == cfm_pkg::CFM_OFF)
		else $error("switch-on from a state other than off");

	open_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_ON_OPEN_WAIT && clk_en && release_req && !fb_closed
		|=> state_q == cfm_pkg::CFM_ON && safety_switching_outputs && !fault_interlock)
		else $error("loop opened in time but not accepted");

	drop_on_release_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_ON && clk_en && monitor_enable && !release_req
		|=> state_q == cfm_pkg::CFM_CLOSE_WAIT && !safety_switching_outputs)
		else $error("release did not switch off and arm the close window");

	close_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_CLOSE_WAIT && clk_en && fb_closed
		|=> state_q == cfm_pkg::CFM_OFF && !fault_interlock)
		else $error("reclosed loop not accepted");

	disabled_on_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == cfm_pkg::CFM_OFF && clk_en && !monitor_enable && release_req
		|=> safety_switching_outputs)
		else $error("switch-on refused while supervision is off");

	no_fault_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		clk_en && !monitor_enable && !fault_interlock |=> !fault_interlock)
		else $error("fault raised while supervision is off");

	clear_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		fault_interlock && clk_en && fault_clear |=> !fault_interlock)
		else $error("interlock held despite clear");
endmodule : cfm_monitor
`default_nettype wire

// >>> cfm_contactor.sv
// partner model: contactor with a positive-guided feedback contact
`default_nettype none
module cfm_contactor (
	input wire logic sys_clk,
	input wire logic coil,
	input wire logic [1:0] mode,
	output logic fb
);
	timeunit 1ns;
	timeprecision 1ns;
	// three cycles of armature travel, so in healthy mode the monitor never sees an instant change
	logic [2:0] sr_q = 3'h7;
	always_ff @(posedge sys_clk) begin
		sr_q <= {sr_q[1:0], ~coil};
	end
	// mode 1 welded closed, mode 2 broken loop, else healthy
	assign fb = (mode == 2'h1) ? 1'b1 : (mode == 2'h2) ? 1'b0 : sr_q[2];
endmodule : cfm_contactor
`default_nettype wire

// >>> contactor_feedback_monitor_bench.sv
// self-checking bench for the contactor feedback monitor
`default_nettype none
`define chk(a, b, m) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("unexpected at %0t: %s", $time, m); end end
module contactor_feedback_monitor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// short window keeps the run small; bounds below follow from it
	localparam int W = 20;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic mon = 1'b1;
	logic req = 1'b0;
	logic clr = 1'b0;
	logic [1:0] mode = 2'h0;
	logic fb, outs, intl, disp;
	logic [31:0] seed = 32'h00006073;
	int miscompares = 0;
	int n_tests = 0;
	int k, np;
	cfm_monitor #(.WINDOW_CYC(W)) uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1),
		.monitor_enable(mon), .release_req(req), .contactor_feedback_input(fb),
		.fault_clear(clr), .safety_switching_outputs(outs), .fault_interlock(intl),
		.display_fault_req(disp));
	cfm_contactor cont (.sys_clk(sys_clk), .coil(outs), .mode(mode), .fb(fb));
	// ==========
	// helpers
	function automatic logic [31:0] rnd(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : rnd
	function automatic logic late_ok(input int n);
		return n >= W - 2 && n <= W + 4;
	endfunction : late_ok
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic wait_fault();
		k = 0;
		np = 0;
		while (intl !== 1'b1 && k < 3 * W) begin
			cyc(1);
			k++;
			np += (disp === 1'b1);
		end
		cyc(1);
		np += (disp === 1'b1);
	endtask : wait_fault
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	// ==========
	// stimulus
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#60000;
		miscompares++;
		end_of_test();
	end
	initial begin
		cyc(4);
		`chk(outs, 1'b0, "outputs on in reset")
		rstn = 1'b1;
		for (int i = 0; i < 4; i++) begin
			seed = rnd(seed);
			req = 1'b1;
			cyc(1);
			`chk(outs, 1'b1, "no switch-on")
			cyc(4 + seed[2:0]);
			req = 1'b0;
			cyc(1);
			`chk(outs, 1'b0, "no switch-off")
			cyc(W + 4);
			`chk(intl, 1'b0, "fault on good cycle")
		end
		$display("test good cycles done");
		mode = 2'h2;
		req = 1'b1;
		cyc(8);
		`chk(outs, 1'b0, "on with open loop")
		mode = 2'h0;
		cyc(2);
		`chk(outs, 1'b1, "on withheld")
		cyc(6);
		mode = 2'h2;
		req = 1'b0;
		wait_fault();
		`chk(late_ok(k), 1'b1, "reclose timing")
		`chk(np, 1, "display request")
		$display("test reclose fault done");
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		`chk(intl, 1'b0, "clear")
		mode = 2'h1;
		req = 1'b1;
		wait_fault();
		`chk(late_ok(k), 1'b1, "open timing")
		`chk(np, 1, "display request")
		cyc(10);
		`chk({outs, intl}, 2'b01, "interlock")
		req = 1'b0;
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		`chk(intl, 1'b0, "clear")
		$display("test open fault done");
		mon = 1'b0;
		mode = 2'h2;
		for (int i = 0; i < 30; i++) begin
			seed = rnd(seed);
			req = seed[4];
			cyc(1);
			`chk(outs, req, "feedback not ignored")
		end
		`chk(intl, 1'b0, "fault while off")
		$display("test disabled done");
		end_of_test();
	end
endmodule : contactor_feedback_monitor_bench
`default_nettype wire
